// file: include/sipc_pkg.sv
// Contract
// - sleep request stops every clock except a needed low-power rc clock and halts execution until a wake event
// - idle request halts the cpu while peripheral clocks keep running
// - enabled interrupt, watchdog time-out or any reset ends sleep or idle
// - entering sleep shuts the system clock source and on-chip oscillator
// - io direction and output values stay frozen throughout sleep
// - clock-failure monitor is kept inactive during sleep
// - low-power rc clock runs in sleep if watchdog or rtc needs it
// - enabled watchdog is cleared just before sleep is entered
// - system-clocked peripherals stop in sleep; external-clocked ones continue
// - after sleep execution resumes on the clock source used before
// - new oscillator select is writable only while clock config is unlocked
// - three-bit priority field gives level directly, 111 highest, 001 lowest
// - priority 000 disables the source for service and for wake-up
// - uart1 rx priority bits 14:12, ccp2 timer bits 2:0, reset 100
package sipc_pkg;

  // register byte offsets
  localparam logic [7:0] INTERRUPT_PRIORITY_CTRL_2_OFS = 8'h00;
  localparam logic [7:0] OSC_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] CLR_OFS  = 8'h0C;
  localparam logic [7:0] IEN_OFS  = 8'h10;
  localparam logic [7:0] MODE_OFS = 8'h14;

  // priority register fields
  localparam int         PRIO_W    = 3;
  localparam int         U1RX_LSB  = 12;
  localparam int         CCP2_LSB  = 0;
  localparam logic [2:0] PRIO_RST  = 3'h4;
  localparam logic [2:0] PRIO_OFF  = 3'h0;

  // oscillator control fields
  localparam int         NOSC_LSB  = 0;
  localparam int         LOCK_BIT  = 3;
  localparam int         COSC_LSB  = 4;
  localparam logic [2:0] NOSC_RST  = 3'h0;

  // status, clear and enable layout
  localparam int EV_W        = 4;
  localparam int EV_SLEEP    = 0;
  localparam int EV_IDLE     = 1;
  localparam int EV_WAKE_IRQ = 2;
  localparam int EV_WAKE_WDT = 3;

  // power-save instruction operand
  localparam logic PS_SLEEP = 1'b0;
  localparam logic PS_IDLE  = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_PREP  = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_IDLE  = 2'b11
  } sipc_pwr_type;

endpackage : sipc_pkg

// file: rtl/sipc_top.sv
module sipc_top #(
  parameter int IO_W = 16
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  // axi4-lite slave
  input  wire logic [7:0]      awaddr_in,
  input  wire logic            awvalid_in,
  output logic                 awready_out,
  input  wire logic [31:0]     wdata_in,
  input  wire logic [3:0]      wstrb_in,
  input  wire logic            wvalid_in,
  output logic                 wready_out,
  output logic [1:0]           bresp_out,
  output logic                 bvalid_out,
  input  wire logic            bready_in,
  input  wire logic [7:0]      araddr_in,
  input  wire logic            arvalid_in,
  output logic                 arready_out,
  output logic [31:0]          rdata_out,
  output logic [1:0]           rresp_out,
  output logic                 rvalid_out,
  input  wire logic            rready_in,
  // core power-save instruction
  input  wire logic            power_save_instruction_valid_in,
  input  wire logic            power_save_instruction_mode_in,
  // wake and configuration sources
  input  wire logic            uart1_rx_irq_in,
  input  wire logic            ccp2_timer_irq_in,
  input  wire logic            wdt_timeout_in,
  input  wire logic            wdt_enable_in,
  input  wire logic            rtc_on_low_power_rc_clock_in,
  input  wire logic            fscm_enable_in,
  // port logic to pins
  input  wire logic [IO_W-1:0] io_dir_in,
  input  wire logic [IO_W-1:0] io_dat_in,
  output logic [IO_W-1:0]      io_dir_out,
  output logic [IO_W-1:0]      io_dat_out,
  // clock controls
  output logic                 cpu_clk_en_out,
  output logic                 sys_clk_en_out,
  output logic                 osc_en_out,
  output logic                 low_power_rc_clock_en_out,
  output logic                 fscm_en_out,
  output logic                 wdt_clear_out,
  output logic [2:0]           cur_osc_out,
  output logic                 uart1_rx_irq_out,
  output logic                 ccp2_timer_irq_out,
  output logic                 irq_out
);

  typedef struct packed {
    sipc_pkg::sipc_pwr_type   pwr;
    logic [2:0]               u1_prio;
    logic [2:0]               ccp2_prio;
    logic [2:0]               nosc;
    logic                     lock;
    logic [2:0]               cosc;
    logic [sipc_pkg::EV_W-1:0] stat;
    logic [sipc_pkg::EV_W-1:0] ien;
    logic                     wdt_clr;
    logic                     cpu_en;
    logic                     sys_en;
    logic                     osc_en;
    logic                     low_power_rc_clock_en;
    logic                     fscm_en;
    logic [IO_W-1:0]          io_dir;
    logic [IO_W-1:0]          io_dat;
    logic                     u1_irq;
    logic                     ccp2_irq;
    logic                     irq;
    logic                     wdt_s1;
    logic                     wdt_s2;
    logic                     aw_got;
    logic                     w_got;
    logic [7:0]               awaddr;
    logic [15:0]              wdata;
    logic [1:0]               wstrb;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [15:0]              rdata;
  } sipc_state_type;

  sipc_state_type s_ff;
  sipc_state_type nxt_s;

  always_comb begin
    logic                      wake_irq;
    logic                      wake_wdt;
    logic                      do_wr;
    logic [sipc_pkg::EV_W-1:0] ev;
    logic [sipc_pkg::EV_W-1:0] clr;
    logic [15:0]               rd;
    nxt_s = s_ff;
    wake_irq = 1'b0;
    wake_wdt = 1'b0;
    do_wr = 1'b0;
    ev = '0;
    clr = '0;
    rd = 16'h0000;

    // watchdog time-out comes from the low_power_rc_clock domain
    nxt_s.wdt_s1 = wdt_timeout_in;
    nxt_s.wdt_s2 = s_ff.wdt_s1;

    // disabled sources neither interrupt nor wake
    nxt_s.u1_irq = uart1_rx_irq_in
                   && (s_ff.u1_prio != sipc_pkg::PRIO_OFF);
    nxt_s.ccp2_irq = ccp2_timer_irq_in
                     && (s_ff.ccp2_prio != sipc_pkg::PRIO_OFF);
    wake_irq = nxt_s.u1_irq || nxt_s.ccp2_irq;
    wake_wdt = s_ff.wdt_s2;

    nxt_s.wdt_clr = 1'b0;
    unique case (s_ff.pwr)
      sipc_pkg::PWR_RUN: begin
        if (power_save_instruction_valid_in) begin
          if (power_save_instruction_mode_in == sipc_pkg::PS_IDLE) begin
            nxt_s.pwr = sipc_pkg::PWR_IDLE;
            ev[sipc_pkg::EV_IDLE] = 1'b1;
          end else begin
            nxt_s.pwr = sipc_pkg::PWR_PREP;
            nxt_s.wdt_clr = wdt_enable_in;
            ev[sipc_pkg::EV_SLEEP] = 1'b1;
          end
        end
      end
      sipc_pkg::PWR_PREP: begin
        nxt_s.pwr = sipc_pkg::PWR_SLEEP;
      end
      sipc_pkg::PWR_SLEEP, sipc_pkg::PWR_IDLE: begin
        if (wake_irq || wake_wdt) begin
          nxt_s.pwr = sipc_pkg::PWR_RUN;
          ev[sipc_pkg::EV_WAKE_IRQ] = wake_irq;
          ev[sipc_pkg::EV_WAKE_WDT] = wake_wdt;
        end
      end
    endcase

    // clock gating follows the next power state
    nxt_s.cpu_en = (nxt_s.pwr == sipc_pkg::PWR_RUN);
    nxt_s.sys_en = (nxt_s.pwr != sipc_pkg::PWR_SLEEP);
    nxt_s.osc_en = (nxt_s.pwr != sipc_pkg::PWR_SLEEP);
    nxt_s.fscm_en = fscm_enable_in
                    && (nxt_s.pwr != sipc_pkg::PWR_SLEEP);
    nxt_s.low_power_rc_clock_en = (nxt_s.pwr != sipc_pkg::PWR_SLEEP)
                    || wdt_enable_in || rtc_on_low_power_rc_clock_in;

    // pins track port logic except while asleep
    if (s_ff.pwr != sipc_pkg::PWR_SLEEP) begin
      nxt_s.io_dir = io_dir_in;
      nxt_s.io_dat = io_dat_in;
    end

    // source only switches while running, so wake keeps it
    if (s_ff.pwr == sipc_pkg::PWR_RUN) begin
      nxt_s.cosc = s_ff.nosc;
    end

    // axi write channels, taken in either order
    if (awvalid_in && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = awaddr_in;
    end
    if (wvalid_in && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = wdata_in[15:0];
      nxt_s.wstrb = wstrb_in[1:0];
    end
    if (s_ff.bvalid && bready_in) begin
      nxt_s.bvalid = 1'b0;
    end
    do_wr = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
    if (do_wr) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = sipc_pkg::RESP_OKAY;
      unique case (s_ff.awaddr)
        sipc_pkg::INTERRUPT_PRIORITY_CTRL_2_OFS: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ccp2_prio = s_ff.wdata[sipc_pkg::CCP2_LSB +: 3];
          end
          if (s_ff.wstrb[1]) begin
            nxt_s.u1_prio = s_ff.wdata[sipc_pkg::U1RX_LSB +: 3];
          end
        end
        sipc_pkg::OSC_OFS: begin
          if (s_ff.wstrb[0]) begin
            if (!s_ff.lock) begin
              nxt_s.nosc = s_ff.wdata[sipc_pkg::NOSC_LSB +: 3];
            end
            if (s_ff.wdata[sipc_pkg::LOCK_BIT]) begin
              nxt_s.lock = 1'b1;
            end
          end
        end
        sipc_pkg::CLR_OFS: begin
          if (s_ff.wstrb[0]) begin
            clr = s_ff.wdata[sipc_pkg::EV_W-1:0];
          end
        end
        sipc_pkg::IEN_OFS: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ien = s_ff.wdata[sipc_pkg::EV_W-1:0];
          end
        end
        sipc_pkg::STAT_OFS, sipc_pkg::MODE_OFS: begin
          nxt_s.bresp = sipc_pkg::RESP_OKAY;
        end
        default: begin
          nxt_s.bresp = sipc_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

    // set beats clear in the same cycle
    nxt_s.stat = (s_ff.stat & ~clr) | ev;
    nxt_s.irq = |(nxt_s.stat & nxt_s.ien);

    // axi read channel
    if (s_ff.rvalid && rready_in) begin
      nxt_s.rvalid = 1'b0;
    end
    if (arvalid_in && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = sipc_pkg::RESP_OKAY;
      unique case (araddr_in)
        sipc_pkg::INTERRUPT_PRIORITY_CTRL_2_OFS: begin
          rd[sipc_pkg::U1RX_LSB +: 3] = s_ff.u1_prio;
          rd[sipc_pkg::CCP2_LSB +: 3] = s_ff.ccp2_prio;
        end
        sipc_pkg::OSC_OFS: begin
          rd[sipc_pkg::NOSC_LSB +: 3] = s_ff.nosc;
          rd[sipc_pkg::LOCK_BIT] = s_ff.lock;
          rd[sipc_pkg::COSC_LSB +: 3] = s_ff.cosc;
        end
        sipc_pkg::STAT_OFS: begin
          rd[sipc_pkg::EV_W-1:0] = s_ff.stat;
        end
        sipc_pkg::IEN_OFS: begin
          rd[sipc_pkg::EV_W-1:0] = s_ff.ien;
        end
        sipc_pkg::CLR_OFS: begin
          rd = 16'h0000;
        end
        sipc_pkg::MODE_OFS: begin
          rd[1:0] = s_ff.pwr;
        end
        default: begin
          nxt_s.rresp = sipc_pkg::RESP_SLVERR;
        end
      endcase
      nxt_s.rdata = rd;
    end
    nxt_s.arready = !nxt_s.rvalid;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_ff <= '0;
      s_ff.pwr <= sipc_pkg::PWR_RUN;
      s_ff.u1_prio <= sipc_pkg::PRIO_RST;
      s_ff.ccp2_prio <= sipc_pkg::PRIO_RST;
      s_ff.nosc <= sipc_pkg::NOSC_RST;
      s_ff.cosc <= sipc_pkg::NOSC_RST;
      s_ff.cpu_en <= 1'b1;
      s_ff.sys_en <= 1'b1;
      s_ff.osc_en <= 1'b1;
      s_ff.low_power_rc_clock_en <= 1'b1;
      s_ff.awready <= 1'b1;
      s_ff.wready <= 1'b1;
      s_ff.arready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready_out        = s_ff.awready;
  assign wready_out         = s_ff.wready;
  assign bresp_out          = s_ff.bresp;
  assign bvalid_out         = s_ff.bvalid;
  assign arready_out        = s_ff.arready;
  assign rdata_out          = {16'h0000, s_ff.rdata};
  assign rresp_out          = s_ff.rresp;
  assign rvalid_out         = s_ff.rvalid;
  assign io_dir_out         = s_ff.io_dir;
  assign io_dat_out         = s_ff.io_dat;
  assign cpu_clk_en_out     = s_ff.cpu_en;
  assign sys_clk_en_out     = s_ff.sys_en;
  assign osc_en_out         = s_ff.osc_en;
  assign low_power_rc_clock_en_out        = s_ff.low_power_rc_clock_en;
  assign fscm_en_out        = s_ff.fscm_en;
  assign wdt_clear_out      = s_ff.wdt_clr;
  assign cur_osc_out        = s_ff.cosc;
  assign uart1_rx_irq_out   = s_ff.u1_irq;
  assign ccp2_timer_irq_out = s_ff.ccp2_irq;
  assign irq_out            = s_ff.irq;

endmodule : sipc_top

// file: verification/sipc_core_model.sv
module sipc_core_model (
  input  wire logic clk_in,
  output logic      power_save_instruction_valid_out,
  output logic      power_save_instruction_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    power_save_instruction_valid_out = 0;
    power_save_instruction_mode_out = 0;
  end
  // one power-save instruction, operand picks sleep or idle
  task automatic exec(input logic m);
    @(posedge clk_in);
    power_save_instruction_valid_out <= 1;
    power_save_instruction_mode_out <= m;
    @(posedge clk_in);
    power_save_instruction_valid_out <= 0;
    power_save_instruction_mode_out <= ~m;
  endtask : exec
endmodule : sipc_core_model

// file: verification/sipc_props.sv
module sipc_props #(
  parameter int IO_W = 16
) (
  input wire logic            clk_in,
  input wire logic            rst_in,
  input wire logic            power_save_instruction_valid_in,
  input wire logic            power_save_instruction_mode_in,
  input wire logic            wdt_timeout_in,
  input wire logic            wdt_enable_in,
  input wire logic            rtc_on_low_power_rc_clock_in,
  input wire logic            uart1_rx_irq_in,
  input wire logic [IO_W-1:0] io_dir_out,
  input wire logic [IO_W-1:0] io_dat_out,
  input wire logic            cpu_clk_en_out,
  input wire logic            sys_clk_en_out,
  input wire logic            osc_en_out,
  input wire logic            low_power_rc_clock_en_out,
  input wire logic            fscm_en_out,
  input wire logic            wdt_clear_out,
  input wire logic [2:0]      cur_osc_out,
  input wire logic            uart1_rx_irq_out,
  input wire logic            ccp2_timer_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_req(logic m);
    power_save_instruction_valid_in && power_save_instruction_mode_in == m && cpu_clk_en_out
      && !$past(power_save_instruction_valid_in);
  endsequence
  // prep cycle: cpu already gated, clocks still up, watchdog clear pulse
  sequence s_prep;
    !cpu_clk_en_out && sys_clk_en_out && osc_en_out
      && wdt_clear_out == $past(wdt_enable_in);
  endsequence
  sequence s_asleep;
    !cpu_clk_en_out && !sys_clk_en_out && !osc_en_out;
  endsequence
  a_sleep_entry: assert property (
    s_req(sipc_pkg::PS_SLEEP) |=> s_prep ##1 s_asleep)
    else $error("sleep entry wrong");
  a_idle_gate: assert property (
    s_req(sipc_pkg::PS_IDLE) |=> !cpu_clk_en_out && sys_clk_en_out)
    else $error("idle entry wrong");
  a_low_power_rc_clock_keep: assert property (
    !sys_clk_en_out |-> low_power_rc_clock_en_out == $past(wdt_enable_in || rtc_on_low_power_rc_clock_in))
    else $error("low_power_rc_clock enable wrong in sleep");
  a_io_frozen: assert property (
    !sys_clk_en_out && $past(!sys_clk_en_out)
      |-> $stable(io_dir_out) && $stable(io_dat_out))
    else $error("io moved in sleep");
  a_fscm_off: assert property (
    !sys_clk_en_out |-> !fscm_en_out)
    else $error("clock monitor on in sleep");
  a_osc_hold: assert property (
    !cpu_clk_en_out |=> $stable(cur_osc_out))
    else $error("clock source changed while halted");
  a_wdt_wake: assert property (
    $rose(wdt_timeout_in) && !cpu_clk_en_out |-> ##[1:4] cpu_clk_en_out)
    else $error("no watchdog wake");
  a_irq_wake: assert property (
    (uart1_rx_irq_out || ccp2_timer_irq_out) && !$past(power_save_instruction_valid_in)
      |-> cpu_clk_en_out)
    else $error("request seen but cpu halted");
  a_irq_gate: assert property (
    uart1_rx_irq_out |-> $past(uart1_rx_irq_in))
    else $error("request out without request in");
endmodule : sipc_props

bind sipc_top sipc_props #(.IO_W(IO_W)) i_props (
  .clk_in, .rst_in, .power_save_instruction_valid_in, .power_save_instruction_mode_in, .wdt_timeout_in,
  .wdt_enable_in, .rtc_on_low_power_rc_clock_in, .uart1_rx_irq_in, .io_dir_out,
  .io_dat_out, .cpu_clk_en_out, .sys_clk_en_out, .osc_en_out,
  .low_power_rc_clock_en_out, .fscm_en_out, .wdt_clear_out, .cur_osc_out,
  .uart1_rx_irq_out, .ccp2_timer_irq_out);

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_in, awvalid_in, wvalid_in, bready_in, arvalid_in;
  logic        rready_in, awready_out, wready_out, bvalid_out, arready_out;
  logic        rvalid_out, power_save_instruction_valid_in, power_save_instruction_mode_in, uart1_rx_irq_in;
  logic        ccp2_timer_irq_in, wdt_timeout_in, wdt_enable_in, osc_en_out;
  logic        rtc_on_low_power_rc_clock_in, fscm_enable_in, cpu_clk_en_out, sys_clk_en_out;
  logic        low_power_rc_clock_en_out, fscm_en_out, wdt_clear_out, uart1_rx_irq_out;
  logic        ccp2_timer_irq_out, irq_out;
  logic [7:0]  awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [3:0]  wstrb_in;
  logic [1:0]  bresp_out, rresp_out;
  logic [2:0]  cur_osc_out;
  logic [15:0] io_dir_in, io_dat_in, io_dir_out, io_dat_out, v;
  int          num_errors, cmp_count, m_interrupt_priority_ctrl_2, m_stat, m_ien, m_nosc, m_lock, j;

  sipc_top i_dut (.clk_in, .rst_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out,
    .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out,
    .rresp_out, .rvalid_out, .rready_in, .power_save_instruction_valid_in, .power_save_instruction_mode_in,
    .uart1_rx_irq_in, .ccp2_timer_irq_in, .wdt_timeout_in, .wdt_enable_in,
    .rtc_on_low_power_rc_clock_in, .fscm_enable_in, .io_dir_in, .io_dat_in, .io_dir_out,
    .io_dat_out, .cpu_clk_en_out, .sys_clk_en_out, .osc_en_out,
    .low_power_rc_clock_en_out, .fscm_en_out, .wdt_clear_out, .cur_osc_out,
    .uart1_rx_irq_out, .ccp2_timer_irq_out, .irq_out);
  sipc_core_model i_core (.clk_in, .power_save_instruction_valid_out(power_save_instruction_valid_in),
    .power_save_instruction_mode_out(power_save_instruction_mode_in));

  initial begin
    clk_in = 0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  task automatic test_done;
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  function automatic int mrd(input int a);
    case (a)
      0: return m_interrupt_priority_ctrl_2;
      4: return m_nosc | m_lock << 3 | m_nosc << 4;
      8: return m_stat;
      16: return m_ien;
      default: return 0;
    endcase
  endfunction : mrd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_in);
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1;
    wvalid_in <= 1;
    bready_in <= 1;
    while (!tb) begin
      @(negedge clk_in);
      ta = awvalid_in & awready_out;
      tw = wvalid_in & wready_out;
      tb = bvalid_out & bready_in;
      r = bresp_out;
      @(posedge clk_in);
      if (ta) awvalid_in <= 0;
      if (tw) wvalid_in <= 0;
    end
    bready_in <= 0;
    chk(r, a > 8'h14 ? sipc_pkg::RESP_SLVERR : sipc_pkg::RESP_OKAY);
    if (a == 0) m_interrupt_priority_ctrl_2 = d & 'h7007;
    if (a == 4 && !m_lock) m_nosc = d & 7;
    if (a == 4 && d & 8) m_lock = 1;
    if (a == 12) m_stat &= ~d;
    if (a == 16) m_ien = d & 'hF;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bit ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_in);
    araddr_in <= a;
    arvalid_in <= 1;
    rready_in <= 1;
    while (!tr) begin
      @(negedge clk_in);
      ta = arvalid_in & arready_out;
      tr = rvalid_out & rready_in;
      d = rdata_out;
      r = rresp_out;
      @(posedge clk_in);
      if (ta) arvalid_in <= 0;
    end
    rready_in <= 0;
    chk(d, mrd(a));
    chk(r, a > 8'h14 ? sipc_pkg::RESP_SLVERR : sipc_pkg::RESP_OKAY);
  endtask : rd

  task automatic wait_run;
    for (int n = 0; n < 20 && cpu_clk_en_out !== 1; n++) @(negedge clk_in);
  endtask : wait_run

  initial begin
    {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 0;
    {uart1_rx_irq_in, ccp2_timer_irq_in, wdt_timeout_in, rtc_on_low_power_rc_clock_in} = 0;
    {awaddr_in, araddr_in, wdata_in, io_dir_in, io_dat_in} = 0;
    {wstrb_in, wdt_enable_in, fscm_enable_in, rst_in} = 7'h7F;
    m_interrupt_priority_ctrl_2 = 'h4004;
    void'($urandom(32'hC965));
    repeat (5) @(posedge clk_in);
    rst_in <= 0;
    rd(0);
    rd(8'h18);
    repeat (4) begin
      wr(0, $urandom);
      rd(0);
    end
    wr(0, 'h0003);
    uart1_rx_irq_in <= 1;
    ccp2_timer_irq_in <= 1;
    repeat (2) @(negedge clk_in);
    chk(uart1_rx_irq_out, 0);
    chk(ccp2_timer_irq_out, 1);
    @(posedge clk_in);
    {uart1_rx_irq_in, ccp2_timer_irq_in} <= 0;
    wr(16, 'hF);
    i_core.exec(sipc_pkg::PS_IDLE);
    @(negedge clk_in);
    chk({cpu_clk_en_out, sys_clk_en_out}, 1);
    m_stat |= 2;
    rd(8);
    chk(irq_out, 1);
    @(posedge clk_in);
    ccp2_timer_irq_in <= 1;
    wait_run;
    m_stat |= 4;
    chk(cpu_clk_en_out, 1);
    @(posedge clk_in);
    ccp2_timer_irq_in <= 0;
    wr(12, 'hF);
    repeat (2) @(negedge clk_in);
    chk(irq_out, 0);
    wr(4, 5);
    wr(4, 'hD);
    wr(4, 2);
    rd(4);
    wr(16, 0);
    wr(0, 'h3003);
    for (j = 0; j < 3; j++) begin
      v = 16'($urandom);
      @(posedge clk_in);
      {io_dir_in, io_dat_in} <= {v, ~v};
      {wdt_enable_in, rtc_on_low_power_rc_clock_in} <= {j == 0, j == 1};
      i_core.exec(sipc_pkg::PS_SLEEP);
      @(negedge clk_in);
      chk(wdt_clear_out, j == 0);
      @(negedge clk_in);
      chk({cpu_clk_en_out, sys_clk_en_out, osc_en_out, fscm_en_out}, 0);
      chk(low_power_rc_clock_en_out, j < 2);
      @(posedge clk_in);
      {io_dir_in, io_dat_in} <= {~v, v};
      repeat (3) @(negedge clk_in);
      chk({io_dir_out, io_dat_out}, {v, ~v});
      chk(cpu_clk_en_out, 0);
      @(posedge clk_in);
      {wdt_timeout_in, uart1_rx_irq_in} <= {j == 0, j != 0};
      wait_run;
      chk({cpu_clk_en_out, cur_osc_out}, 4'hD);
      m_stat |= j == 0 ? 'h9 : 'h5;
      @(posedge clk_in);
      {wdt_timeout_in, uart1_rx_irq_in} <= 0;
      rd(8);
      chk(irq_out, 0);
    end
    wr(16, 'hF);
    repeat (2) @(negedge clk_in);
    chk(irq_out, 1);
    test_done();
  end
endmodule : testbench
